/* File: shared/hfa_pkg.sv */
// package of the half-flash converter host: register map, fields, timing
// assumes a 20 MHz pclk; all pin timing is counted in pclk cycles
package hfa_pkg;
  // register byte offsets on the apb side
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_CMD   = 8'h04;
  localparam logic [7:0] ADDR_STAT  = 8'h08;
  localparam logic [7:0] ADDR_ISTAT = 8'h0C;
  localparam logic [7:0] ADDR_IMASK = 8'h10;
  // control fields
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_PIPE_BIT = 1;
  localparam int CTRL_SHDN_BIT = 2;
  // command fields: channel in [2:0], start strobe
  localparam int CMD_START_BIT = 8;
  // interrupt status / mask fields
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_WAKE_BIT = 1;
  // reset values
  localparam logic [2:0] CTRL_RST  = 3'h0;
  localparam logic [1:0] IMASK_RST = 2'h0;
  // timing in ns, as given, and derived cycle counts
  localparam int CLK_NS      = 50;
  localparam int WAKE_NS     = 360;
  localparam int ACQ_NS      = 260;
  localparam int WR_PULSE_NS = 400;
  localparam int ACC_NS      = 130;
  localparam int SYNC_LAT    = 3;
  localparam logic [3:0] WAKE_CYC = 4'((WAKE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] ACQ_CYC  = 4'((ACQ_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WR_CYC   = 4'((WR_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] ACC_CYC  =
    4'((ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT);
  // conversion sequencer states
  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_STROBE = 3'b001,
    S_WAIT   = 3'b010,
    S_ACCESS = 3'b011,
    S_GAP    = 3'b100
  } hfa_state_e;
endpackage : hfa_pkg

/* File: src/hfa_sync.sv */
// three-stage synchroniser with agreement filter for converter pins
// assumes the inputs are asynchronous to pclk
module hfa_sync #(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      dout <= RST;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        dout <= s3_q; // change counts once stages two and three agree
    end
  end
endmodule : hfa_sync

/* File: src/hfa_host.sv */
// apb-controlled host for an 8-bit half-flash converter's parallel port
// assumes the converter pins are asynchronous; the wr/ready pin is resolved
// from wr_oe by the surroundings, with an external pull-up for ready
//
// Overview of operation
// - the host holds read low to take data; the converter drives only then.
// - every read or write strobe is issued with chip select held low.
// - the channel number goes out in binary, msb on the highest pin.
// - after wake-up the host waits 8 pclk cycles (400 ns, at least 360 ns) before starting a conversion.
// - read mode starts with chip select and read low, done flag ends it.
// - tied strobes start a new conversion and return the previous result.
module hfa_host (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic                       irq,
  output logic                       cs_n,
  output logic                       rd_n,
  output logic                       wr_o,
  output logic                       wr_oe,
  input  wire logic                  wr_rdy_i,
  output logic                       mode_o,
  output logic                       shutdown_input_n,
  output logic                       channel_select_msb,
  output logic                       channel_select_mid,
  output logic                       channel_select_lsb,
  input  wire logic [7:0]            data_i,
  input  wire logic                  int_n_i
);
  import hfa_pkg::*;

  hfa_state_e  state_q;
  logic [3:0]  cnt_q;
  logic [3:0]  wcnt_q;
  logic [2:0]  ctrl_q;
  logic [1:0]  imask_q;
  logic [1:0]  istat_q;
  logic [7:0]  result_q;
  logic        awake_q;
  logic        pipe_q;
  logic        start_req;
  logic        done_ev;
  logic        wake_ev;
  logic        wr_acc;
  logic        rd_acc;
  logic [9:0]  pin_s;
  logic [7:0]  data_s;
  logic        int_n_s;
  logic        rdy_s;

  // pins from the converter pass the agreement synchroniser
  hfa_sync #(.W(10), .RST(10'h300)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({int_n_i, wr_rdy_i, data_i}),
    .dout    (pin_s)
  );
  assign data_s  = pin_s[7:0];
  assign rdy_s   = pin_s[8];
  assign int_n_s = pin_s[9];

  // access phase qualifiers; pready is always high in the access phase
  assign wr_acc    = psel && penable && pready && pwrite;
  assign rd_acc    = psel && penable && pready && !pwrite;
  assign start_req = wr_acc && (paddr == ADDR_CMD) && pwdata[CMD_START_BIT];

  // apb answer is prepared in the setup cycle so pready comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable)
      begin
        if (paddr == ADDR_CTRL)
          prdata <= {29'h0, ctrl_q};
        else if (paddr == ADDR_CMD)
          prdata <= 32'h0000_0000;
        else if (paddr == ADDR_STAT)
          prdata <= {16'h0, result_q, 4'h0, rdy_s, !int_n_s, awake_q,
                     state_q != S_IDLE};
        else if (paddr == ADDR_ISTAT)
          prdata <= {30'h0, istat_q};
        else if (paddr == ADDR_IMASK)
          prdata <= {30'h0, imask_q};
        else
          pslverr <= 1'b1; // unmapped offset
      end
    end
  end

  // control and mask registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q  <= CTRL_RST;
      imask_q <= IMASK_RST;
    end
    else
    begin
      if (wr_acc && paddr == ADDR_CTRL)
        ctrl_q <= pwdata[2:0];
      if (wr_acc && paddr == ADDR_IMASK)
        imask_q <= pwdata[1:0];
    end
  end

  // sticky events, read clears; a new event in the same cycle survives
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      istat_q <= 2'h0;
    else
    begin
      if (rd_acc && paddr == ADDR_ISTAT)
        istat_q <= {wake_ev, done_ev};
      else
        istat_q <= istat_q | {wake_ev, done_ev};
    end
  end

  // level interrupt from the unmasked sticky bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(istat_q & imask_q);
  end

  // shutdown pin and wake-up wait; starts are refused until awake
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shutdown_input_n <= 1'b1;
      awake_q          <= 1'b0;
      wcnt_q           <= WAKE_CYC;
      wake_ev          <= 1'b0;
    end
    else
    begin
      shutdown_input_n <= !ctrl_q[CTRL_SHDN_BIT];
      wake_ev          <= 1'b0;
      if (!shutdown_input_n)
      begin
        awake_q <= 1'b0;
        wcnt_q  <= WAKE_CYC;
      end
      else if (!awake_q)
      begin
        wcnt_q <= wcnt_q - 4'h1;
        if (wcnt_q == 4'h1)
        begin
          awake_q <= 1'b1;
          wake_ev <= 1'b1;
        end
      end
    end
  end

  // mode pin and shared-pin direction change only between conversions
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_o <= 1'b0;
      wr_oe  <= 1'b0;
      pipe_q <= 1'b0;
    end
    else if (state_q == S_IDLE)
    begin
      mode_o <= ctrl_q[CTRL_MODE_BIT];
      wr_oe  <= ctrl_q[CTRL_MODE_BIT];
      pipe_q <= ctrl_q[CTRL_PIPE_BIT] && ctrl_q[CTRL_MODE_BIT];
    end
  end

  // conversion sequencer; no timeout on the done flag, a dead part hangs it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q  <= S_IDLE;
      cnt_q    <= 4'h0;
      cs_n     <= 1'b1;
      rd_n     <= 1'b1;
      wr_o     <= 1'b1;
      result_q <= 8'h00;
      done_ev  <= 1'b0;
      channel_select_msb <= 1'b0;
      channel_select_mid <= 1'b0;
      channel_select_lsb <= 1'b0;
    end
    else
    begin
      done_ev <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          if (start_req && awake_q)
          begin
            channel_select_msb <= pwdata[2];
            channel_select_mid <= pwdata[1];
            channel_select_lsb <= pwdata[0];
            cs_n <= 1'b0;
            if (!ctrl_q[CTRL_MODE_BIT])
            begin
              rd_n    <= 1'b0;
              state_q <= S_WAIT;
            end
            else
            begin
              wr_o    <= 1'b0;
              rd_n    <= !ctrl_q[CTRL_PIPE_BIT];
              cnt_q   <= WR_CYC;
              state_q <= S_STROBE;
            end
          end
        end
        S_STROBE:
        begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1)
          begin
            wr_o <= 1'b1;
            if (pipe_q)
            begin
              result_q <= data_s;
              rd_n     <= 1'b1;
              cs_n     <= 1'b1;
              done_ev  <= 1'b1;
              cnt_q    <= ACQ_CYC;
              state_q  <= S_GAP;
            end
            else
              state_q <= S_WAIT;
          end
        end
        S_WAIT:
        begin
          if (!int_n_s)
          begin
            rd_n    <= 1'b0;
            cnt_q   <= ACC_CYC;
            state_q <= S_ACCESS;
          end
        end
        S_ACCESS:
        begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1)
          begin
            result_q <= data_s;
            rd_n     <= 1'b1;
            cs_n     <= 1'b1;
            done_ev  <= 1'b1;
            cnt_q    <= ACQ_CYC;
            state_q  <= S_GAP;
          end
        end
        S_GAP:
        begin
          // acquisition time before the next start, flag recovers meanwhile
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1)
            state_q <= S_IDLE;
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  rd_cs_a: assert property (!rd_n |-> !cs_n)
    else $error("read strobe without chip select");
  wr_cs_a: assert property (wr_oe && !wr_o |-> !cs_n)
    else $error("write strobe without chip select");
  rdmode_pin_a: assert property (!mode_o |-> !wr_oe)
    else $error("shared pin driven in read mode");
  wr_width_a: assert property ($fell(wr_o) |-> !wr_o [*8] ##1 wr_o)
    else $error("write pulse width wrong");
  access_rd_a: assert property (state_q == S_ACCESS |-> !rd_n && !cs_n)
    else $error("data taken without read strobe");
  chan_stable_a: assert property (!cs_n && $past(!cs_n) |->
    $stable({channel_select_msb, channel_select_mid, channel_select_lsb}))
    else $error("channel changed during access");
  mode_stable_a: assert property (!cs_n |-> $stable(mode_o))
    else $error("mode changed during access");
  wake_wait_a: assert property ($rose(shutdown_input_n) |->
    cs_n [*8])
    else $error("conversion started before wake-up time");
  shdn_pin_a: assert property (ctrl_q[CTRL_SHDN_BIT] |=>
    !shutdown_input_n)
    else $error("shutdown pin not driven low");
  wait_int_a: assert property (state_q == S_WAIT && !int_n_s |=>
    state_q == S_ACCESS && !rd_n)
    else $error("done flag not followed by read");
  irq_level_a: assert property (|(istat_q & imask_q) |=> irq)
    else $error("interrupt not raised");

  rdmode_c: cover property (!mode_o && $fell(rd_n) ##[1:40] done_ev);
  wrmode_c: cover property (mode_o && !pipe_q && $fell(wr_o)
    ##[1:60] done_ev);
  pipe_c: cover property (pipe_q && $fell(wr_o) ##[1:20] done_ev);
  wake_c: cover property (wake_ev);
endmodule : hfa_host

/* File: tb/hfa_adc_model.sv */
// converter model: clockless pin behaviour of the half-flash device
// assumes the bench resolves the shared wr/ready pin with a pull-up
module hfa_adc_model #(
  parameter int CONV_NS = 700,
  parameter int INTL_NS = 300
) (
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       mode,
  input  wire logic       shdn_n,
  input  wire logic [2:0] ch,
  output logic      [7:0] data,
  output logic            int_n,
  output logic            rdy_n,
  output int              err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] res_q;
  logic [7:0] buf_q = 8'h00;
  logic       busy = 1'b0;
  realtime    wake_t = 0;
  int         seq = 0;
  initial int_n = 1'b1;
  initial rdy_n = 1'b1;
  initial err = 0;
  // released lines show the inverse, so a stale sample never matches
  assign data = (!cs_n && !rd_n && (mode || !busy)) ? buf_q : ~buf_q;
  always @(posedge shdn_n) wake_t = $realtime;
  // a start counts as a host fault while asleep or still waking
  task automatic start();
    if (!shdn_n || $realtime < wake_t + 360.0) err++;
    res_q = (ch == 3'h7) ? 8'hFF : {ch, seq[4:0]};
    seq++;
    busy = 1'b1;
  endtask : start
  // read mode: the falling strobe pair starts the conversion, which ends CONV_NS later
  always @(negedge (cs_n | rd_n))
    if (!mode)
    begin
      start();
      rdy_n = 1'b0;
      #(CONV_NS);
      buf_q = res_q;
      busy = 1'b0;
      int_n = 1'b0;
      rdy_n = 1'b1;
    end
  // write-read mode: falling write starts, rising write latches upper half
  always @(negedge wr_n)
    if (mode && !cs_n)
    begin
      start();
      int_n = 1'b1;
    end
  always @(posedge wr_n)
    if (mode && busy)
    begin
      buf_q[7:4] = res_q[7:4];
      #(INTL_NS);
      if (busy)
      begin
        buf_q[3:0] = res_q[3:0];
        busy = 1'b0;
        int_n = 1'b0;
      end
    end
  // early read forces the lower half out at once
  always @(negedge rd_n)
  begin
    if (cs_n) err++;
    if (mode && busy && wr_n && !cs_n)
    begin
      buf_q = res_q;
      busy = 1'b0;
      int_n = 1'b0;
    end
  end
  always @(posedge cs_n or posedge rd_n) int_n = 1'b1;
endmodule : hfa_adc_model

/* File: tb/hfa_host_tb.sv */
// bench of the converter host: apb driver, scoreboard and converter model
// assumes hfa_pkg and an external pull-up on the shared wr/ready pin
module hfa_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import hfa_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err_q;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic        pready, pslverr, irq, cs_n, rd_n, wr_o, wr_oe, mode_o;
  logic        shdn_n, ch2, ch1, ch0, int_n, rdy_n;
  logic [7:0]  data;
  wire         wr_pin;
  int          n_fail = 0, n_compared = 0, cyc = 0, seq = 0, last = 0, m_err;
  always #25 pclk = ~pclk;
  // ready is open drain, so a released pin reads high
  assign wr_pin = wr_oe ? wr_o : rdy_n;
  hfa_host hfa_host_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .cs_n(cs_n),
    .rd_n(rd_n), .wr_o(wr_o), .wr_oe(wr_oe), .wr_rdy_i(wr_pin),
    .mode_o(mode_o), .shutdown_input_n(shdn_n),
    .channel_select_msb(ch2), .channel_select_mid(ch1),
    .channel_select_lsb(ch0), .data_i(data), .int_n_i(int_n));
  hfa_adc_model hfa_adc_model_inst (
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_pin), .mode(mode_o),
    .shdn_n(shdn_n), .ch({ch2, ch1, ch0}), .data(data), .int_n(int_n),
    .rdy_n(rdy_n), .err(m_err));
  task automatic final_report();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // wide enough for a 32-bit word plus the error flag beside it
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_awake();
    int k;
    k = 0;
    rd_q = 32'h0;
    while (!rd_q[1] && k < 50)
    begin
      apb(1'b0, ADDR_STAT, 32'h0);
      k++;
    end
    apb(1'b0, ADDR_ISTAT, 32'h0);
    chk(rd_q[1], 1'b1);
    apb(1'b0, ADDR_ISTAT, 32'h0);
    chk(rd_q[1], 1'b0);
  endtask : wait_awake
  // one conversion; pipelined mode returns the previous result
  task automatic conv(input logic [1:0] mp, input logic [2:0] c,
                      input logic msk);
    int nv;
    int k;
    nv = (c == 3'h7) ? 255 : c * 32 + seq % 32;
    apb(1'b1, ADDR_IMASK, {31'h0, msk});
    apb(1'b1, ADDR_CTRL, {30'h0, mp});
    apb(1'b1, ADDR_CMD, {23'h0, 1'b1, 5'h0, c});
    @(posedge pclk);
    chk({cs_n, mode_o, wr_oe, ch2, ch1, ch0}, {1'b0, mp[0], mp[0], c});
    k = 0;
    rd_q = 32'h1;
    while (rd_q[0] && k < 100)
    begin
      apb(1'b0, ADDR_STAT, 32'h0);
      k++;
    end
    chk(rd_q[15:8], (mp == 2'h3) ? last : nv);
    chk(irq, msk);
    apb(1'b0, ADDR_ISTAT, 32'h0);
    chk(rd_q[0], 1'b1);
    @(posedge pclk);
    chk(irq, 1'b0);
    last = nv;
    seq++;
    $display("conversion done: mode %0d channel %0d", mp, c);
  endtask : conv
  // cut a hang short
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_fail++;
      $display("[FAIL] %0t run timed out", $time);
      final_report();
    end
  end
  initial
  begin
    void'($urandom(32'hC060));
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk({cs_n, rd_n, wr_oe, mode_o, shdn_n, irq}, 6'b110010);
    @(posedge pclk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd_q, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({err_q, rd_q}, {1'b1, 32'h0});
    wait_awake();
    $display("registers and wake-up done");
    for (int k = 0; k < 8; k++)
      conv(2'h0, 3'(k), 1'b1);
    repeat (3)
      conv(2'h1, 3'($urandom_range(7, 0)), 1'b1);
    conv(2'h1, 3'($urandom_range(7, 0)), 1'b0);
    repeat (3)
      conv(2'h3, 3'($urandom_range(7, 0)), 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h4);
    @(posedge pclk);
    chk(shdn_n, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0);
    wait_awake();
    conv(2'h1, 3'h7, 1'b1);
    chk(m_err, 0);
    $display("shutdown and wake-up done");
    final_report();
  end
endmodule : hfa_host_tb
